// ==== oip_pkg.sv ====
// Constants, register map and state types for the overcurrent and inrush protection block.
// Assumes a 100 MHz system clock and a 10 ms protection tick derived from it.
package oip_pkg;

  localparam int CUR_W = 16;
  localparam int NSTG = 5;
  localparam int NCFG = 16;

  // Timing base: every protection delay is counted in 10 ms ticks
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_MS = 10;
  localparam int TICK_CYCLES_DFLT = TICK_MS * 1000000 / CLK_PERIOD_NS;
  localparam int START_MS = 20;
  localparam int ACT_MS = 40;
  localparam int HOLD_MS = 150;
  localparam logic [15:0] START_TICKS = 16'((START_MS + TICK_MS - 1) / TICK_MS);
  localparam logic [15:0] ACT_TICKS = 16'((ACT_MS + TICK_MS - 1) / TICK_MS);
  localparam logic [15:0] HOLD_TICKS = 16'((HOLD_MS + TICK_MS - 1) / TICK_MS);

  // Register indices; byte address is four times the index
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_INV_PICK = 5'h01;
  localparam logic [4:0] REG_INV_TP = 5'h02;
  localparam logic [4:0] REG_RES_TRIP0 = 5'h03;
  localparam logic [4:0] REG_RES_DLY0 = 5'h06;
  localparam logic [4:0] REG_HARM_PCT = 5'h09;
  localparam logic [4:0] REG_HARM_TIME = 5'h0a;
  localparam logic [4:0] REG_NS1_PICK = 5'h0b;
  localparam logic [4:0] REG_NS1_DLY = 5'h0c;
  localparam logic [4:0] REG_NS1_ACC = 5'h0d;
  localparam logic [4:0] REG_NS2_PICK = 5'h0e;
  localparam logic [4:0] REG_NS2_DLY = 5'h0f;
  localparam logic [4:0] REG_STATUS = 5'h10;

  // Control register fields
  localparam int CTL_ARC_EN = 0;
  localparam int CTL_HARM_EN = 1;
  localparam int CTL_RES_EN = 2;
  localparam int CTL_RES_INV = 5;
  localparam int CTL_NS_INV = 8;
  localparam int CTL_NS_ACCEL = 9;
  localparam int CTL_NS_EN = 10;

  // Reset values, index 15 first; currents in 0,001 In, times in ticks
  localparam logic [NCFG-1:0][15:0] CFG_RST = {
    16'h000a, 16'h0064, 16'h000a, 16'h0064, 16'h0064,
    16'h002d, 16'h0019, 16'h000f, 16'h000f, 16'h000f,
    16'h03e8, 16'h03e8, 16'h012c, 16'h000c, 16'h0028, 16'h0c1f};

  typedef enum logic [2:0] {
    HB_IDLE = 3'b001,
    HB_BLOCK = 3'b010,
    HB_WAIT = 3'b100
  } oip_hb_t;

  typedef struct packed {
    logic [NCFG-1:0][15:0] cfg;
    logic wr_pend;
    logic [3:0] wr_idx;
    logic [31:0] rdata;
    logic rdy;
    logic [19:0] tick_cnt;
    logic tick;
    oip_hb_t hb;
    logic [15:0] hb_cnt;
    logic hblk;
    logic [NSTG-1:0][15:0] tcnt;
    logic [NSTG-1:0][31:0] acc;
    logic [NSTG-1:0] st;
    logic [NSTG-1:0] tr;
    logic [15:0] hold;
    logic cmd;
    logic arc;
  } oip_state_t;

endpackage

// ==== oip_top.sv ====
// Residual and negative-sequence overcurrent stages with second-harmonic inrush restraint.
// Assumes measured magnitudes arrive synchronous to hclk and settings come over AHB-Lite.
//
// Operation
// - Intermittent-arc detection stage output can be disabled entirely by configuration.
// - Each residual stage selects inverse-time or definite-time operation.
// - Residual stages enable individually and use no directional criterion.
// - Inverse stage pickup defaults 0,04 In in 0,001 In steps, time 0,12 s.
// - Residual start-up after 20 ms, activation no sooner than 40 ms.
// - Three definite residual stages: trip defaults 0,3 In, 1 In, 1 In.
// - Definite residual delays default 0,15 s, range 0,05 to 60 s, 0,01 s.
// - Delay is total operate time; activation time lies within it.
// - Second harmonic above threshold inhibits overcurrent start-ups; here only the residual stages, never the negative-sequence stages.
// - Detected inrush blocks overcurrent triggering for the set blocking time; the negative-sequence stages are not blocked.
// - Per-phase harmonic detections are ORed; blocking can be disabled.
// - After blocking time, protection resumes even if harmonic persists.
// - Harmonic threshold defaults 25 %, 10 to 50 % in 5 % steps.
// - Blocking time defaults 450 ms, 50 to 3000 ms in 10 ms steps.
// - Trip timers of blocked functions are held cleared during blocking.
// - Negative-sequence function is dependent-time or independent-time, never both; stage one is always definite-time, so with stage two inverse it is both.
// - Two negative-sequence stages; first has accelerated delay, second may be inverse.
// - Negative-sequence current is compared continuously against both stage settings.
// - Each stage raises start, then trip, reported separately.
// - Leaving the region before the delay ends drops start and pending trip.
// - Trip command holds while the fault lasts and at least 150 ms.
//
// Design decisions made here: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/10ps
module oip_top #(
  parameter int TICK_CYCLES = oip_pkg::TICK_CYCLES_DFLT
) (
  input wire logic hclk, // System clock
  input wire logic hresetn, // Asynchronous reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size, words only
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout, // Slave ready
  output logic hresp, // Always OKAY
  output logic [31:0] hrdata, // Read data
  input wire logic [oip_pkg::CUR_W-1:0] res_cur_i, // Residual current, 0,001 In
  input wire logic [oip_pkg::CUR_W-1:0] neg_seq_cur_i, // Negative-sequence current, 0,001 In
  input wire logic [oip_pkg::CUR_W-1:0] fund_a_i, // Phase A fundamental
  input wire logic [oip_pkg::CUR_W-1:0] fund_b_i, // Phase B fundamental
  input wire logic [oip_pkg::CUR_W-1:0] fund_c_i, // Phase C fundamental
  input wire logic [oip_pkg::CUR_W-1:0] harm2_a_i, // Phase A second harmonic
  input wire logic [oip_pkg::CUR_W-1:0] harm2_b_i, // Phase B second harmonic
  input wire logic [oip_pkg::CUR_W-1:0] harm2_c_i, // Phase C second harmonic
  input wire logic arc_event_i, // Arc detector event
  output logic [2:0] res_start_o, // Residual stage starts
  output logic [2:0] res_trip_o, // Residual stage trips
  output logic [1:0] neg_start_o, // Negative-sequence starts
  output logic [1:0] neg_trip_o, // Negative-sequence trips
  output logic breaker_trip_o, // Trip command to breaker
  output logic harm_block_o, // Inrush blocking active
  output logic arc_stage_o // Intermittent arc stage output
);
  import oip_pkg::*;

  oip_state_t s;
  oip_state_t n;
  logic [NSTG-1:0] ov;

  function automatic logic harm_over(input logic [15:0] h2, input logic [15:0] fund, input logic [15:0] pct);
    harm_over = (24'(h2) * 24'd100) > (24'(fund) * 24'(pct));
  endfunction

  always_comb begin
    logic [15:0] meas;
    logic [15:0] pick;
    logic [15:0] dly;
    logic inv;
    logic en;
    logic blk;
    logic det;
    logic any_tr;
    logic [31:0] tgt;
    logic [5:0] idx;
    meas = '0;
    pick = '0;
    dly = '0;
    inv = 1'b0;
    en = 1'b0;
    blk = 1'b0;
    tgt = '0;
    ov = '0;
    det = 1'b0;
    any_tr = 1'b0;
    idx = '0;
    n = s;
    // Zero wait states: data phase always completes in one cycle
    n.rdy = 1'b1;
    if (s.wr_pend) begin
      n.cfg[s.wr_idx] = hwdata[15:0];
    end
    n.wr_pend = 1'b0;
    idx = haddr[7:2];
    if (hsel && htrans[1] && hready) begin
      n.rdata = 32'h0000_0000;
      if (haddr[31:8] == 24'h00_0000 && idx < 6'(NCFG)) begin
        n.wr_pend = hwrite;
        n.wr_idx = idx[3:0];
        n.rdata = {16'h0000, n.cfg[idx[3:0]]};
      end else if (haddr[31:8] == 24'h00_0000 && idx == 6'(REG_STATUS)) begin
        n.rdata = {19'h0, s.arc, s.cmd, s.hblk, s.tr, s.st};
      end
    end
    // Common protection tick
    n.tick = 1'b0;
    if (s.tick_cnt >= 20'(TICK_CYCLES - 1)) begin
      n.tick_cnt = '0;
      n.tick = 1'b1;
    end else begin
      n.tick_cnt = s.tick_cnt + 20'h00001;
    end
    // Inrush restraint
    det = s.cfg[REG_CTRL][CTL_HARM_EN] && (harm_over(harm2_a_i, fund_a_i, s.cfg[REG_HARM_PCT]) ||
      harm_over(harm2_b_i, fund_b_i, s.cfg[REG_HARM_PCT]) || harm_over(harm2_c_i, fund_c_i, s.cfg[REG_HARM_PCT]));
    unique case (s.hb)
      HB_IDLE: begin
        if (det) begin
          n.hb = HB_BLOCK;
          n.hb_cnt = '0;
        end
      end
      HB_BLOCK: begin
        if (!s.cfg[REG_CTRL][CTL_HARM_EN]) begin
          n.hb = HB_IDLE;
        end else if (s.tick) begin
          // Re-arming waits for the harmonic to fall, so a long inrush cannot block forever
          if (s.hb_cnt + 16'h0001 >= s.cfg[REG_HARM_TIME]) begin
            n.hb = HB_WAIT;
          end else begin
            n.hb_cnt = s.hb_cnt + 16'h0001;
          end
        end
      end
      HB_WAIT: begin
        if (!det) begin
          n.hb = HB_IDLE;
        end
      end
      default: begin
        n.hb = HB_IDLE;
      end
    endcase
    n.hblk = (n.hb == HB_BLOCK);
    // Stages 0-2 residual, 3 negative-sequence one, 4 negative-sequence two
    for (int k = 0; k < NSTG; k++) begin
      if (k < 3) begin
        meas = res_cur_i;
        en = s.cfg[REG_CTRL][CTL_RES_EN + k];
        inv = s.cfg[REG_CTRL][CTL_RES_INV + k];
        pick = inv ? s.cfg[REG_INV_PICK] : s.cfg[REG_RES_TRIP0 + 5'(k)];
        dly = inv ? s.cfg[REG_INV_TP] : s.cfg[REG_RES_DLY0 + 5'(k)];
        blk = s.hblk;
      end else if (k == 3) begin
        meas = neg_seq_cur_i;
        en = s.cfg[REG_CTRL][CTL_NS_EN];
        inv = 1'b0;
        pick = s.cfg[REG_NS1_PICK];
        dly = s.cfg[REG_CTRL][CTL_NS_ACCEL] ? s.cfg[REG_NS1_ACC] : s.cfg[REG_NS1_DLY];
        blk = 1'b0;
      end else begin
        meas = neg_seq_cur_i;
        en = s.cfg[REG_CTRL][CTL_NS_EN + 1];
        inv = s.cfg[REG_CTRL][CTL_NS_INV];
        pick = s.cfg[REG_NS2_PICK];
        dly = s.cfg[REG_NS2_DLY];
        blk = 1'b0;
      end
      ov[k] = en && (meas >= pick);
      if (!ov[k] || blk) begin
        n.tcnt[k] = '0;
        n.acc[k] = '0;
      end else if (s.tick) begin
        if (s.tcnt[k] != 16'hffff) begin
          n.tcnt[k] = s.tcnt[k] + 16'h0001;
        end
        // Inverse: integrate excess current, so time falls as current rises
        if (!s.tr[k]) begin
          n.acc[k] = s.acc[k] + (inv ? 32'(meas - pick) : 32'h0000_0001);
        end
      end
      tgt = inv ? 32'(dly) * 32'(pick) : 32'(dly);
      n.st[k] = ov[k] && !blk && (n.tcnt[k] >= START_TICKS);
      n.tr[k] = ov[k] && !blk && (n.tcnt[k] >= ACT_TICKS) && (n.acc[k] >= tgt);
    end
    // Trip hold
    any_tr = |n.tr;
    if (any_tr && !s.cmd) begin
      n.hold = HOLD_TICKS;
    end else if (s.tick && s.hold != 16'h0000) begin
      n.hold = s.hold - 16'h0001;
    end
    n.cmd = any_tr || (n.hold != 16'h0000);
    n.arc = s.cfg[REG_CTRL][CTL_ARC_EN] && arc_event_i;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
      s.cfg <= CFG_RST;
      s.rdy <= 1'b1;
      s.hb <= HB_IDLE;
    end else begin
      s <= n;
    end
  end

  assign hreadyout = s.rdy;
  assign hresp = 1'b0;
  assign hrdata = s.rdata;
  assign res_start_o = s.st[2:0];
  assign res_trip_o = s.tr[2:0];
  assign neg_start_o = s.st[4:3];
  assign neg_trip_o = s.tr[4:3];
  assign breaker_trip_o = s.cmd;
  assign harm_block_o = s.hblk;
  assign arc_stage_o = s.arc;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_arc_off;
    !s.cfg[REG_CTRL][CTL_ARC_EN] |=> !arc_stage_o;
  endproperty
  a_arc_off: assert property (p_arc_off) else $error("arc stage active while disabled");

  property p_res_disabled;
    !s.cfg[REG_CTRL][CTL_RES_EN] |=> !res_start_o[0] && !res_trip_o[0];
  endproperty
  a_res_disabled: assert property (p_res_disabled) else $error("disabled residual stage active");

  property p_start_time;
    $rose(res_start_o[0]) |-> s.tcnt[0] == START_TICKS;
  endproperty
  a_start_time: assert property (p_start_time) else $error("residual start not at 20 ms");

  property p_act_min;
    $rose(s.tr[0]) |-> s.tcnt[0] >= ACT_TICKS;
  endproperty
  a_act_min: assert property (p_act_min) else $error("trip before activation time");

  property p_block_clear;
    harm_block_o |=> res_start_o == 3'b000 && res_trip_o == 3'b000 && s.tcnt[0] == 16'h0000;
  endproperty
  a_block_clear: assert property (p_block_clear) else $error("residual timer runs while blocked");

  property p_harm_off;
    !s.cfg[REG_CTRL][CTL_HARM_EN] ##1 !s.cfg[REG_CTRL][CTL_HARM_EN] |=> !harm_block_o;
  endproperty
  a_harm_off: assert property (p_harm_off) else $error("blocking while feature disabled");

  property p_block_expire;
    s.hb == HB_BLOCK && s.tick && s.cfg[REG_CTRL][CTL_HARM_EN] && (s.hb_cnt + 16'h0001 >= s.cfg[REG_HARM_TIME])
      |=> !harm_block_o ##1 !harm_block_o;
  endproperty
  a_block_expire: assert property (p_block_expire) else $error("blocking outlasts blocking time");

  property p_leave_region;
    !ov[3] |=> !neg_start_o[0] && !neg_trip_o[0];
  endproperty
  a_leave_region: assert property (p_leave_region) else $error("stage held after leaving region");

  property p_trip_hold;
    $rose(breaker_trip_o) |=> breaker_trip_o [*8];
  endproperty
  a_trip_hold: assert property (p_trip_hold) else $error("trip command too short");

  property p_trip_follows;
    (|s.tr) |-> breaker_trip_o;
  endproperty
  a_trip_follows: assert property (p_trip_follows) else $error("stage trip without breaker command");

  property p_bus_okay;
    hreadyout && !hresp;
  endproperty
  a_bus_okay: assert property (p_bus_okay) else $error("bus slave not ready or not okay");

  // The tick must stay a single-cycle pulse, or every delay would run fast
  property p_tick_pulse;
    s.tick |=> !s.tick;
  endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("tick longer than one cycle");

  property p_tick_count;
    s.tick_cnt < 20'(TICK_CYCLES);
  endproperty
  a_tick_count: assert property (p_tick_count) else $error("tick divider out of range");

  property p_harm_detect;
    s.hb == HB_IDLE && s.cfg[REG_CTRL][CTL_HARM_EN] && harm_over(harm2_b_i, fund_b_i, s.cfg[REG_HARM_PCT])
      |=> harm_block_o;
  endproperty
  a_harm_detect: assert property (p_harm_detect) else $error("inrush not blocked");

  property p_block_start;
    $rose(harm_block_o) |-> s.hb_cnt == 16'h0000;
  endproperty
  a_block_start: assert property (p_block_start) else $error("blocking time not restarted");

  property p_block_cnt;
    harm_block_o |-> s.hb_cnt < s.cfg[REG_HARM_TIME];
  endproperty
  a_block_cnt: assert property (p_block_cnt) else $error("blocking count past setting");

  property p_no_rearm;
    s.hb == HB_WAIT |-> !harm_block_o;
  endproperty
  a_no_rearm: assert property (p_no_rearm) else $error("blocking while waiting for harmonic to fall");

  property p_res2_disabled;
    !s.cfg[REG_CTRL][CTL_RES_EN + 2] |=> !res_start_o[2] && !res_trip_o[2];
  endproperty
  a_res2_disabled: assert property (p_res2_disabled) else $error("disabled third stage active");

  property p_def_delay;
    $rose(s.tr[0]) && !s.cfg[REG_CTRL][CTL_RES_INV] |-> s.tcnt[0] >= s.cfg[REG_RES_DLY0];
  endproperty
  a_def_delay: assert property (p_def_delay) else $error("definite trip before its delay");

  property p_trip_needs_start;
    res_trip_o[0] |-> res_start_o[0];
  endproperty
  a_trip_needs_start: assert property (p_trip_needs_start) else $error("trip without start");

  property p_ns_start;
    $rose(neg_start_o[0]) |-> s.tcnt[3] == START_TICKS;
  endproperty
  a_ns_start: assert property (p_ns_start) else $error("negative-sequence start mistimed");

  property p_ns_trip_min;
    $rose(neg_trip_o[0]) |-> s.tcnt[3] >= ACT_TICKS;
  endproperty
  a_ns_trip_min: assert property (p_ns_trip_min) else $error("negative-sequence trip too early");

  property p_ns_disabled;
    !s.cfg[REG_CTRL][CTL_NS_EN] |=> !neg_start_o[0] && !neg_trip_o[0];
  endproperty
  a_ns_disabled: assert property (p_ns_disabled) else $error("disabled negative-sequence stage active");

  property p_ns2_leave;
    !ov[4] |=> !neg_start_o[1] && !neg_trip_o[1];
  endproperty
  a_ns2_leave: assert property (p_ns2_leave) else $error("second stage held after leaving region");

  property p_hold_load;
    $rose(breaker_trip_o) |-> s.hold == HOLD_TICKS;
  endproperty
  a_hold_load: assert property (p_hold_load) else $error("trip hold not loaded");

  // Counting the hold down can never end the command early
  property p_cmd_hold;
    breaker_trip_o && s.hold > 16'h0001 |=> breaker_trip_o;
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("trip command dropped during hold");

  property p_arc_follow;
    s.cfg[REG_CTRL][CTL_ARC_EN] && arc_event_i |=> arc_stage_o;
  endproperty
  a_arc_follow: assert property (p_arc_follow) else $error("enabled arc stage missed event");

  c_res_trip: cover property ($rose(res_trip_o[0]));
  c_ns_accel: cover property (s.cfg[REG_CTRL][CTL_NS_ACCEL] && $rose(neg_trip_o[0]));
  c_block: cover property ($rose(harm_block_o) ##[1:1000] $fell(harm_block_o));
  c_neg_trip: cover property ($rose(neg_trip_o[1]));
  c_cmd_end: cover property ($fell(breaker_trip_o));

endmodule

// ==== oip_fe_model.sv ====
// Partner model: measurement front end feeding magnitudes, breaker side timing the trip command.
// Assumes the bench changes the set values just after a rising hclk edge.
`timescale 1ns/10ps
module oip_fe_model #(
  parameter int HOLD_CYC = 140
) (
  input wire logic hclk, // Clock
  input wire logic [15:0] res_v, // Residual magnitude to present
  input wire logic [15:0] ns_v, // Negative-sequence magnitude to present
  input wire logic [15:0] fund_v, // Fundamental, all phases
  input wire logic [2:0][15:0] h2_v, // Second harmonic per phase
  input wire logic trip_i, // Breaker command from the block
  output logic [15:0] res_o, // Residual sample
  output logic [15:0] ns_o, // Negative-sequence sample
  output logic [15:0] fund_o, // Fundamental sample
  output logic [2:0][15:0] h2_o, // Harmonic samples
  output int short_cnt // Trip commands shorter than the hold
);
  int len = 0;
  int sc = 0;
  assign short_cnt = sc;
  // A fresh sample every clock, one cycle behind the set values
  always @(posedge hclk) begin
    res_o <= res_v;
    ns_o <= ns_v;
    fund_o <= fund_v;
    h2_o <= h2_v;
    if (trip_i === 1'b1) begin
      len <= len + 1;
    end else begin
      if (len != 0 && len < HOLD_CYC) sc <= sc + 1;
      len <= 0;
    end
  end
endmodule

// ==== overcurrent_inrush_protection_tb_top.sv ====
// Testbench: AHB-Lite register tasks and timed protection scenarios.
// Assumes oip_top with a 10-cycle tick and the front-end partner model.
`timescale 1ns/10ps
module overcurrent_inrush_protection_tb_top;
  import oip_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, arc_ev, brk, blk, arc_o;
  logic [1:0] htrans, ns_s, ns_t;
  logic [2:0] hsize, rs, rt;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [15:0] res_v, ns_v, fund_v, res_i, ns_i, fa;
  logic [2:0][15:0] h2_v, h2_i;
  int bad_count, checks, sc, c;

  oip_top #(.TICK_CYCLES(10)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .res_cur_i(res_i), .neg_seq_cur_i(ns_i),
    .fund_a_i(fa), .fund_b_i(fa), .fund_c_i(fa), .harm2_a_i(h2_i[0]), .harm2_b_i(h2_i[1]),
    .harm2_c_i(h2_i[2]), .arc_event_i(arc_ev), .res_start_o(rs), .res_trip_o(rt), .neg_start_o(ns_s),
    .neg_trip_o(ns_t), .breaker_trip_o(brk), .harm_block_o(blk), .arc_stage_o(arc_o));
  oip_fe_model #(.HOLD_CYC(140)) fe (.hclk(hclk), .res_v(res_v), .ns_v(ns_v), .fund_v(fund_v),
    .h2_v(h2_v), .trip_i(brk), .res_o(res_i), .ns_o(ns_i), .fund_o(fa), .h2_o(h2_i), .short_cnt(sc));

  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic rng(input string n, input int v, input int lo, input int hi);
    checks++;
    if (v < lo || v > hi) begin
      bad_count++;
      $display("unexpected %s exp %0d..%0d got %0d", n, lo, hi, v);
    end
  endtask
  task automatic bus(input logic w, input logic [4:0] i, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {25'h0, i, 2'b00};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [4:0] i, input logic [31:0] d);
    bus(1'b1, i, d);
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return rs[0];
      1: return rt[0];
      2: return ~blk;
      3: return ns_t[0];
      default: return ~brk;
    endcase
  endfunction
  // Bounded wait; c keeps counting cycles across calls
  task automatic upto(input int s);
    while (sig(s) !== 1'b1 && c < 400) begin
      @(posedge hclk);
      c++;
    end
  endtask

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    bad_count++;
    test_done();
  end
  initial begin
    {hresetn, hsel, hwrite, arc_ev, htrans, haddr, hwdata} = '0;
    {res_v, ns_v, h2_v} = '0;
    hsize = 3'b010;
    fund_v = 16'h03e8;
    bad_count = 0;
    checks = 0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 17; i++) begin
      bus(1'b0, 5'(i), '0);
      chk("reg reset", (i < 16) ? {16'h0, CFG_RST[i]} : 32'h0, rd);
    end
    chk("hresp", 32'h0, {31'h0, hresp});
    wr(5'h11, 32'h1234);
    bus(1'b0, 5'h11, '0);
    chk("unmapped", 32'h0, rd);
    wr(REG_STATUS, 32'hffff);
    bus(1'b0, REG_STATUS, '0);
    chk("status ro", 32'h0, rd);
    wr(REG_RES_DLY0, 32'h6);
    bus(1'b0, REG_RES_DLY0, '0);
    chk("dly readback", 32'h6, rd);
    res_v <= 16'h012c;
    c = 0;
    upto(0);
    rng("start time", c, 10, 32);
    chk("upper starts", 32'h0, {30'h0, rs[2:1]});
    upto(1);
    rng("trip time", c, 50, 75);
    repeat (2) @(posedge hclk);
    bus(1'b0, REG_STATUS, '0);
    chk("status", 32'h0821, rd & 32'h0821);
    res_v <= '0;
    c = 0;
    upto(4);
    rng("trip hold", c, 130, 170);
    res_v <= 16'h012c;
    repeat (40) @(posedge hclk);
    chk("start", 32'h1, {31'h0, rs[0]});
    res_v <= '0;
    repeat (3) @(posedge hclk);
    chk("start drop", 32'h0, {31'h0, rs[0]});
    repeat (60) @(posedge hclk);
    chk("no trip", 32'h0, {28'h0, rt, brk});
    wr(REG_CTRL, 32'h0c17);
    res_v <= 16'h03e8;
    repeat (40) @(posedge hclk);
    chk("enables", 32'h5, {29'h0, rs});
    res_v <= '0;
    repeat (5) @(posedge hclk);
    wr(REG_CTRL, 32'h0c3f);
    for (int k = 0; k < 2; k++) begin
      res_v <= k ? 16'h0064 : 16'h0118;
      c = 0;
      upto(1);
      rng("inverse trip", c, k ? 70 : 30, k ? 95 : 55);
      res_v <= '0;
      repeat (5) @(posedge hclk);
    end
    wr(REG_CTRL, 32'h0c1f);
    wr(REG_HARM_TIME, 32'h5);
    for (int p = 0; p < 4; p++) begin
      h2_v[p % 3] <= (p < 3) ? 16'h0104 : 16'h00fa;
      repeat (3) @(posedge hclk);
      chk("block", {31'h0, p < 3}, {31'h0, blk});
      h2_v <= '0;
      repeat (60) @(posedge hclk);
    end
    res_v <= 16'h012c;
    h2_v[1] <= 16'h012c;
    repeat (3) @(posedge hclk);
    c = 0;
    upto(2);
    rng("block time", c, 35, 55);
    chk("held clear", 32'h0, {31'h0, rs[0]});
    c = 0;
    upto(1);
    rng("trip after block", c, 50, 75);
    res_v <= '0;
    h2_v <= '0;
    repeat (3) @(posedge hclk);
    wr(REG_CTRL, 32'h0c1d);
    h2_v[2] <= 16'h03e8;
    repeat (3) @(posedge hclk);
    chk("harm off", 32'h0, {31'h0, blk});
    h2_v <= '0;
    wr(REG_NS1_DLY, 32'h8);
    wr(REG_NS1_ACC, 32'h5);
    for (int k = 0; k < 2; k++) begin
      wr(REG_CTRL, k ? 32'h0e1f : 32'h0c1f);
      ns_v <= 16'h0064;
      c = 0;
      upto(3);
      rng("ns trip", c, k ? 40 : 70, k ? 65 : 95);
      chk("ns starts", 32'h3, {30'h0, ns_s});
      ns_v <= '0;
      repeat (5) @(posedge hclk);
    end
    wr(REG_CTRL, 32'h001f);
    ns_v <= 16'h0064;
    arc_ev <= 1'b1;
    repeat (40) @(posedge hclk);
    chk("ns off", 32'h0, {30'h0, ns_s});
    chk("arc on", 32'h1, {31'h0, arc_o});
    wr(REG_CTRL, 32'h001e);
    repeat (2) @(posedge hclk);
    chk("arc off", 32'h0, {31'h0, arc_o});
    repeat (200) @(posedge hclk);
    chk("short trips", 32'h0, 32'(sc));
    test_done();
  end
endmodule
